//--- verilog/lishx_exec.v
// execution unit for loop, interrupt enable, sign extend, halt and port input
//
// The plain strobed port and the register offsets were left to the implementer.
`timescale 1ns/1ps
`include "lishx_consts.vh"
// How it works
// - loop decrements counter, branches if nonzero, else falls through
// - branch target is next-instruction address minus twice displacement
// - displacement is unsigned seven bits, 0 to 127
// - segmented taken branch changes offset only, segment kept
// - loop target always backward, never into another segment
// - loop word has top nibble 1111; 11 cycles; flags kept
// - interrupt enable sets vectored and/or nonvectored enables; 7 cycles
// - bit 0 zero sets nonvectored enable, bit 1 zero sets vectored
// - select bit one leaves enable alone; other control bits kept
// - sign extend copies bit 7, 15 or 31 into upper half
// - byte, word, long forms use codes 0000, 1010, 0111
// - halt waits for interrupt or reset, resumes after halt
// - while halted refresh continues and bus requests are granted
// - halted core samples interrupts every three cycles; 8 plus 3n
// - input loads port into destination; indirect 10, direct 12 cycles
// - low bit of 010S selects standard or special input cycle
// - special select bit is one for special, zero for standard
module lishx_exec #(
  parameter PC_W = 16
)(
  input wire clk_i,
  input wire reset_n_i,
  input wire instr_valid_i,
  input wire [15:0] instr_i,
  input wire [15:0] ext_word_i,
  input wire [PC_W-1:0] next_pc_i,
  input wire [7:0] pc_seg_i,
  input wire system_mode_i,
  input wire [63:0] rd_data_i,
  input wire [15:0] rs_data_i,
  input wire vi_en_i,
  input wire nvi_en_i,
  input wire irq_pending_i,
  input wire refresh_req_i,
  input wire bus_hold_request_i,
  input wire [15:0] port_data_i,
  input wire port_ack_i,
  output wire busy_o,
  output reg done_o,
  output reg pc_load_o,
  output reg [PC_W-1:0] pc_offset_o,
  output reg [7:0] pc_seg_o,
  output reg rd_we_o,
  output reg [2:0] rd_size_o,
  output reg [3:0] rd_sel_o,
  output reg [63:0] rd_wdata_o,
  output reg fcw_we_o,
  output reg vectored_irq_enable_o,
  output reg nonvectored_irq_enable_o,
  output reg trap_o,
  output reg halted_o,
  output reg irq_accept_o,
  output reg refresh_o,
  output wire bus_grant_o,
  output reg port_rd_o,
  output reg port_special_o,
  output reg port_byte_o,
  output reg [15:0] port_addr_o
);
  localparam S_IDLE = 3'h0;
  localparam S_WAIT = 3'h1;
  localparam S_HALT = 3'h2;
  localparam S_PORT = 3'h3;
  localparam OP_LOOP = 3'h0;
  localparam OP_EI = 3'h1;
  localparam OP_EXT = 3'h2;
  localparam OP_HALT = 3'h3;
  localparam OP_IN = 3'h4;
  localparam OP_TRAP = 3'h5;
  localparam OP_NONE = 3'h7;

  reg [2:0] state_reg;
  reg [2:0] state_next;
  reg [7:0] cnt_reg;
  reg [7:0] cnt_next;
  reg [2:0] op_reg;
  reg [15:0] ir_reg;
  reg [63:0] res_reg;
  reg [2:0] op_dec;
  reg [7:0] cyc_dec;
  reg is_ir_in;
  reg [15:0] cnt16;
  reg [PC_W-1:0] target;
  reg [63:0] ext_val;

  // decode; input forms split by bits 15:9, the direct form also needs the 010S sub-opcode
  always @*
  begin
    op_dec = OP_NONE;
    cyc_dec = `LISHX_CYC_TRAP;
    is_ir_in = 1'b0;
    if (instr_i[15:12] == `LISHX_LOOP_TOP)
    begin
      op_dec = OP_LOOP;
      cyc_dec = `LISHX_CYC_LOOP;
    end
    else if (instr_i[15:8] == `LISHX_EI_HI && instr_i[7:2] == `LISHX_EI_LO6)
    begin
      op_dec = OP_EI;
      cyc_dec = `LISHX_CYC_EI;
    end
    else if (instr_i[15:8] == `LISHX_EXT_TOP && (instr_i[3:0] == `LISHX_EXT_B
      || instr_i[3:0] == `LISHX_EXT_W || instr_i[3:0] == `LISHX_EXT_L))
    begin
      op_dec = OP_EXT;
      cyc_dec = `LISHX_CYC_EXT;
    end
    else if (instr_i[15:8] == `LISHX_HALT_HI && instr_i[7:0] == `LISHX_HALT_LO)
    begin
      op_dec = OP_HALT;
      cyc_dec = `LISHX_CYC_HALT;
    end
    else if (instr_i[15:9] == `LISHX_IN_IR_TOP && instr_i[7:4] != 4'h0)
    begin
      op_dec = OP_IN;
      is_ir_in = 1'b1;
      cyc_dec = `LISHX_CYC_IN_IR;
    end
    else if (instr_i[15:9] == `LISHX_IN_DA_TOP && instr_i[3:1] == `LISHX_IN_DA_SUB)
    begin
      op_dec = OP_IN;
      cyc_dec = `LISHX_CYC_IN_DA;
    end
    // privileged forms trap outside system mode
    if (!system_mode_i && (op_dec == OP_EI || op_dec == OP_HALT || op_dec == OP_IN))
    begin
      op_dec = OP_TRAP;
      cyc_dec = `LISHX_CYC_TRAP;
    end
  end

  // loop counter decrement, word or byte half of register
  always @*
  begin
    cnt16 = 16'h0000;
    if (instr_i[7])
      cnt16 = rd_data_i[15:0] - 16'h0001;
    else
      cnt16 = {8'h00, rd_data_i[7:0] - 8'h01};
    // unsigned 7-bit disp doubled, always subtracted: backward only
    target = next_pc_i - {{(PC_W-8){1'b0}}, instr_i[6:0], 1'b0};
  end

  // sign extension of the destination low half
  always @*
  begin
    ext_val = rd_data_i;
    case (instr_i[3:0])
      `LISHX_EXT_B: ext_val = {48'h0, {8{rd_data_i[7]}}, rd_data_i[7:0]};
      `LISHX_EXT_W: ext_val = {32'h0, {16{rd_data_i[15]}}, rd_data_i[15:0]};
      default: ext_val = {{32{rd_data_i[31]}}, rd_data_i[31:0]};
    endcase
  end

  assign busy_o = (state_reg != S_IDLE);
  // bus held requests honoured in halt (and whenever idle between instructions)
  assign bus_grant_o = bus_hold_request_i && (state_reg == S_HALT || state_reg == S_IDLE);

  // counter next value
  always @*
  begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    case (state_reg)
      S_IDLE:
      begin
        if (instr_valid_i && op_dec != OP_NONE)
        begin
          state_next = (op_dec == OP_IN) ? S_PORT : S_WAIT;
          // halt leaves wait a cycle early so its first wake check lands on cycle 8
          if (op_dec == OP_HALT)
            cnt_next = cyc_dec - 8'h02;
          else
            cnt_next = cyc_dec - 8'h01;
        end
      end
      S_WAIT:
      begin
        if (cnt_reg != 8'h00)
          cnt_next = cnt_reg - 8'h01;
        else if (op_reg == OP_HALT)
        begin
          state_next = S_HALT;
          cnt_next = 8'h00; // first interrupt check on the next edge
        end
        else
          state_next = S_IDLE;
      end
      S_HALT:
      begin
        // interrupts looked at only at each period end
        if (cnt_reg != 8'h00)
          cnt_next = cnt_reg - 8'h01;
        else if (irq_pending_i)
          state_next = S_IDLE;
        else
          cnt_next = `LISHX_HALT_PERIOD - 8'h01;
      end
      S_PORT:
      begin
        if (cnt_reg != 8'h00)
          cnt_next = cnt_reg - 8'h01;
        // a slow port stretches the instruction past its nominal count
        else if (port_ack_i)
          state_next = S_IDLE;
      end
      default:
        state_next = S_IDLE;
    endcase
  end

  // sequencing and outputs; all writes land on the last cycle
  always @(posedge clk_i)
  begin
    if (!reset_n_i)
    begin
      state_reg <= S_IDLE;
      cnt_reg <= 8'h00;
      op_reg <= OP_NONE;
      ir_reg <= 16'h0000;
      res_reg <= 64'h0;
      done_o <= 1'b0;
      pc_load_o <= 1'b0;
      pc_offset_o <= {PC_W{1'b0}};
      pc_seg_o <= 8'h00;
      rd_we_o <= 1'b0;
      rd_size_o <= 3'h0;
      rd_sel_o <= 4'h0;
      rd_wdata_o <= 64'h0;
      fcw_we_o <= 1'b0;
      vectored_irq_enable_o <= 1'b0;
      nonvectored_irq_enable_o <= 1'b0;
      trap_o <= 1'b0;
      halted_o <= 1'b0;
      irq_accept_o <= 1'b0;
      refresh_o <= 1'b0;
      port_rd_o <= 1'b0;
      port_special_o <= 1'b0;
      port_byte_o <= 1'b0;
      port_addr_o <= 16'h0000;
    end
    else
    begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      done_o <= 1'b0;
      pc_load_o <= 1'b0;
      rd_we_o <= 1'b0;
      fcw_we_o <= 1'b0;
      trap_o <= 1'b0;
      irq_accept_o <= 1'b0;
      refresh_o <= (state_reg == S_HALT) && refresh_req_i;
      halted_o <= (state_next == S_HALT);
      if (state_reg == S_IDLE && instr_valid_i && op_dec != OP_NONE)
      begin
        op_reg <= op_dec;
        ir_reg <= instr_i;
        case (op_dec)
          OP_LOOP:
          begin
            res_reg <= {48'h0, cnt16};
            pc_offset_o <= target;
            pc_seg_o <= pc_seg_i;
          end
          OP_EXT: res_reg <= ext_val;
          OP_EI:
          begin
            // clear select bit turns enable on, set bit keeps it
            vectored_irq_enable_o <= vi_en_i | ~instr_i[1];
            nonvectored_irq_enable_o <= nvi_en_i | ~instr_i[0];
          end
          OP_IN:
          begin
            port_addr_o <= is_ir_in ? rs_data_i : ext_word_i;
            // register form has no select bit: always a standard cycle
            port_special_o <= ~is_ir_in & instr_i[0];
            port_byte_o <= ~instr_i[8];
            port_rd_o <= 1'b1;
          end
          default: res_reg <= res_reg;
        endcase
      end
      if (state_reg == S_PORT && cnt_reg == 8'h00 && port_ack_i)
      begin
        port_rd_o <= 1'b0;
        rd_we_o <= 1'b1;
        rd_size_o <= port_byte_o ? 3'h0 : 3'h1;
        // register form keeps the destination in the low nibble
        rd_sel_o <= (ir_reg[15:9] == `LISHX_IN_IR_TOP) ? ir_reg[3:0] : ir_reg[7:4];
        rd_wdata_o <= {48'h0, port_byte_o ? {8'h00, port_data_i[7:0]} : port_data_i};
        done_o <= 1'b1;
      end
      if (state_reg == S_WAIT && cnt_reg == 8'h00 && op_reg != OP_HALT)
      begin
        done_o <= 1'b1;
        case (op_reg)
          OP_LOOP:
          begin
            rd_we_o <= 1'b1;
            rd_size_o <= ir_reg[7] ? 3'h1 : 3'h0;
            rd_sel_o <= ir_reg[11:8];
            rd_wdata_o <= res_reg;
            pc_load_o <= (res_reg[15:0] != 16'h0000);
          end
          OP_EXT:
          begin
            rd_we_o <= 1'b1;
            rd_size_o <= (ir_reg[3:0] == `LISHX_EXT_B) ? 3'h1 :
              (ir_reg[3:0] == `LISHX_EXT_W) ? 3'h2 : 3'h3;
            rd_sel_o <= ir_reg[7:4];
            rd_wdata_o <= res_reg;
          end
          OP_EI: fcw_we_o <= 1'b1;
          OP_TRAP: trap_o <= 1'b1;
          default: done_o <= 1'b1;
        endcase
      end
      // wake: core services the interrupt, then runs the next instruction
      if (state_reg == S_HALT && cnt_reg == 8'h00 && irq_pending_i)
      begin
        irq_accept_o <= 1'b1;
        done_o <= 1'b1;
      end
    end
  end
endmodule

//--- verilog/lishx_consts.vh
// constants for the loop, interrupt-enable, sign-extend, halt and input execution unit
`ifndef LISHX_CONSTS_VH
`define LISHX_CONSTS_VH
`define LISHX_LOOP_TOP 4'hF
`define LISHX_EI_HI 8'h7C
`define LISHX_EI_LO6 6'h01
`define LISHX_HALT_HI 8'h7A
`define LISHX_HALT_LO 8'h00
`define LISHX_EXT_TOP 8'hB1
`define LISHX_EXT_B 4'h0
`define LISHX_EXT_W 4'hA
`define LISHX_EXT_L 4'h7
`define LISHX_IN_IR_TOP 7'h1E
`define LISHX_IN_DA_TOP 7'h1D
`define LISHX_IN_DA_SUB 3'h2
`define LISHX_CYC_LOOP 8'h0B
`define LISHX_CYC_EI 8'h07
`define LISHX_CYC_EXT 8'h0B
`define LISHX_CYC_HALT 8'h08
`define LISHX_HALT_PERIOD 8'h03
`define LISHX_CYC_IN_IR 8'h0A
`define LISHX_CYC_IN_DA 8'h0C
`define LISHX_CYC_TRAP 8'h01
`define LISHX_FCW_VI 1'h1
`define LISHX_FCW_NVI 1'h0
`endif

//--- tb/lishx_props.sv
// assertion checker for the execution unit
`timescale 1ns/1ps
`include "lishx_consts.vh"
module lishx_props (
  input wire clk_i,
  input wire reset_n_i,
  input wire instr_valid_i,
  input wire [15:0] instr_i,
  input wire system_mode_i,
  input wire bus_hold_request_i,
  input wire refresh_req_i,
  input wire port_ack_i,
  input wire busy_o,
  input wire done_o,
  input wire rd_we_o,
  input wire fcw_we_o,
  input wire trap_o,
  input wire halted_o,
  input wire irq_accept_o,
  input wire bus_grant_o,
  input wire refresh_o,
  input wire port_rd_o,
  input wire port_special_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  // decode of the instruction taken at this edge
  wire tk = instr_valid_i && !busy_o;
  wire lp = tk && instr_i[15:12] == `LISHX_LOOP_TOP;
  wire ei = tk && instr_i[15:2] == {`LISHX_EI_HI, `LISHX_EI_LO6};
  wire ht = tk && instr_i == {`LISHX_HALT_HI, `LISHX_HALT_LO};
  wire da = tk && instr_i[15:9] == `LISHX_IN_DA_TOP && instr_i[3:1] == `LISHX_IN_DA_SUB;
  wire ir = tk && instr_i[15:9] == `LISHX_IN_IR_TOP && instr_i[7:4] != 4'h0;
  wire ex = tk && instr_i[15:8] == `LISHX_EXT_TOP && instr_i[3:0] inside {4'h0, 4'hA, 4'h7};
  wire pv = ei || ht || da || ir;
  reg [7:0] hcnt_reg = 8'h00;
  // cycles since halt was taken, so the wake-up step can be judged
  always @(posedge clk_i)
    hcnt_reg <= (!reset_n_i || done_o) ? 8'h00 : (ht && system_mode_i) ? 8'h01 :
      (hcnt_reg != 8'h00) ? hcnt_reg + 8'h01 : 8'h00;
  // a pulse launched on edge N is sampled high at edge N+1
  loop_time_a: assert property (lp |=> (!done_o) [*8] ##1 (!done_o) [*3] ##1
    (done_o && rd_we_o)) else $error("loop timing wrong");
  ei_time_a: assert property (ei && system_mode_i |-> ##8 (done_o && fcw_we_o))
    else $error("enable timing wrong");
  ext_time_a: assert property (ex |-> ##12 (done_o && rd_we_o))
    else $error("extend timing wrong");
  priv_trap_a: assert property (pv && !system_mode_i |-> ##2 (trap_o && !fcw_we_o && !rd_we_o))
    else $error("no trap in normal mode");
  halt_step_a: assert property (irq_accept_o |-> hcnt_reg >= 8'h09 &&
    (hcnt_reg - 8'h09) % 8'h03 == 8'h00) else $error("halt wake off period");
  refresh_on_a: assert property (halted_o && refresh_req_i |=> refresh_o)
    else $error("refresh missing while halted");
  bus_grant_a: assert property (halted_o || !busy_o |-> bus_grant_o == bus_hold_request_i)
    else $error("bus hold not granted");
  in_kind_a: assert property (da && system_mode_i |=> port_rd_o &&
    port_special_o == $past(instr_i[0])) else $error("input cycle kind wrong");
  port_hold_a: assert property (port_rd_o && !port_ack_i |=> port_rd_o)
    else $error("port read dropped early");
  cover property (irq_accept_o);
  cover property (pv && !system_mode_i ##2 trap_o);
  cover property (port_rd_o && port_special_o && port_ack_i);
endmodule
bind lishx_exec lishx_props i_lishx_props (.clk_i, .reset_n_i, .instr_valid_i, .instr_i,
  .system_mode_i, .bus_hold_request_i, .port_ack_i, .busy_o, .done_o, .rd_we_o, .fcw_we_o,
  .trap_o, .halted_o, .irq_accept_o, .bus_grant_o, .port_rd_o, .port_special_o,
  .refresh_req_i, .refresh_o);

//--- tb/lishx_port_model.sv
// port side model answering input cycles
`timescale 1ns/1ps
module lishx_port_model (
  input wire clk_i,
  input wire reset_n_i,
  input wire port_rd_i,
  input wire [15:0] port_addr_i,
  input wire [7:0] lat_i,
  output reg port_ack_o = 1'b0,
  output reg [15:0] port_data_o = 16'hA5A5
);
  reg [7:0] wait_reg = 8'h00;
  // ack stands while the read does; off the bus the data keep toggling
  always @(posedge clk_i)
  begin
    wait_reg <= port_rd_i ? wait_reg + 8'h01 : 8'h00;
    port_ack_o <= reset_n_i && port_rd_i && wait_reg >= lat_i;
    port_data_o <= (reset_n_i && port_rd_i && wait_reg >= lat_i) ?
      port_addr_i ^ 16'h5A3C : ~port_data_o;
  end
endmodule

//--- tb/tb_lishx_exec.sv
// self-checking bench for the execution unit
`timescale 1ns/1ps
`include "lishx_consts.vh"
module tb_lishx_exec;
  typedef struct {logic rdw; logic [2:0] sz; logic [63:0] msk; logic [63:0] wd; logic pcl;
    logic [3:0] sel; logic [15:0] pco; logic flag_control_word; logic vi; logic nonvectored_irq_enable; logic trp;
    int cyc; int take;} lishx_note_t;
  logic clk_i = 0, reset_n_i = 0, instr_valid_i = 0, system_mode_i = 1, vi_en_i = 0;
  logic nvi_en_i = 0, irq_pending_i = 0, refresh_req_i = 0, bus_hold_request_i = 0;
  logic [15:0] instr_i = 0, ext_word_i = 0, next_pc_i = 0, rs_data_i = 0, a, c;
  logic [7:0] pc_seg_i = 0, lat = 0;
  logic [63:0] rd_data_i = 0, d;
  logic [6:0] dp;
  logic [1:0] f;
  wire [15:0] port_data_i, pc_offset_o, port_addr_o;
  wire port_ack_i, busy_o, done_o, pc_load_o, rd_we_o, fcw_we_o, vectored_irq_enable_o;
  wire nonvectored_irq_enable_o, trap_o, halted_o, irq_accept_o, refresh_o, bus_grant_o;
  wire port_rd_o, port_special_o, port_byte_o;
  wire [7:0] pc_seg_o;
  wire [2:0] rd_size_o;
  wire [3:0] rd_sel_o;
  wire [63:0] rd_wdata_o;
  int num_errors = 0, tests_run = 0, cyc = 0, i;
  lishx_note_t notes[$];
  lishx_note_t n, m;
  lishx_exec #(.PC_W(16)) i_lishx_exec (.clk_i, .reset_n_i, .instr_valid_i, .instr_i,
    .ext_word_i, .next_pc_i, .pc_seg_i, .system_mode_i, .rd_data_i, .rs_data_i, .vi_en_i,
    .nvi_en_i, .irq_pending_i, .refresh_req_i, .bus_hold_request_i, .port_data_i, .port_ack_i,
    .busy_o, .done_o, .pc_load_o, .pc_offset_o, .pc_seg_o, .rd_we_o, .rd_size_o, .rd_sel_o,
    .rd_wdata_o, .fcw_we_o, .vectored_irq_enable_o, .nonvectored_irq_enable_o, .trap_o,
    .halted_o, .irq_accept_o, .refresh_o, .bus_grant_o, .port_rd_o, .port_special_o,
    .port_byte_o, .port_addr_o);
  lishx_port_model i_lishx_port_model (.clk_i(clk_i), .reset_n_i(reset_n_i),
    .port_rd_i(port_rd_o), .port_addr_i(port_addr_o), .lat_i(lat), .port_ack_o(port_ack_i),
    .port_data_o(port_data_i));
  always #2 clk_i = ~clk_i;
  // counted on the falling edge so both processes read it settled
  always @(negedge clk_i) cyc <= cyc + 1;
  task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic results();
    $display("checks %0d errors %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // one request, held to its take edge, then waited out under a bound
  task automatic op(input logic [15:0] ins, input lishx_note_t e, input int irq_at);
    int w;
    instr_i <= ins;
    instr_valid_i <= 1'b1;
    @(posedge clk_i);
    e.take = cyc;
    notes.push_back(e);
    instr_valid_i <= 1'b0;
    w = 0;
    do
    begin
      @(posedge clk_i);
      w++;
      {refresh_req_i, bus_hold_request_i} <= 2'($urandom);
      if (w == irq_at) irq_pending_i <= 1'b1;
    end
    while (busy_o !== 1'b0 && w < 400);
    // a stuck instruction counts as a mismatch
    if (w >= 400) num_errors++;
    irq_pending_i <= 1'b0;
  endtask
  // completion watcher: oldest note against each finished instruction
  always @(posedge clk_i)
    if (done_o === 1'b1)
    begin
      m = notes.pop_front();
      chk("rd_we", rd_we_o, m.rdw);
      if (m.rdw) chk("rd_wdata", rd_wdata_o & m.msk, m.wd);
      if (m.rdw) chk("rd_size", rd_size_o, m.sz);
      if (m.rdw && m.sel != 4'h0) chk("rd_sel", rd_sel_o, m.sel);
      chk("pc_load", pc_load_o, m.pcl);
      if (m.pcl) chk("target", {pc_seg_o, pc_offset_o}, {pc_seg_i, m.pco});
      chk("fcw_we", fcw_we_o, m.flag_control_word);
      if (m.flag_control_word) chk("enables", {vectored_irq_enable_o, nonvectored_irq_enable_o}, {m.vi, m.nonvectored_irq_enable});
      chk("trap", trap_o, m.trp);
      if (m.cyc > 0) chk("cycles", cyc - m.take, m.cyc + 1);
    end
  // hang guard far above the expected run length
  always @(posedge clk_i)
    if (cyc == 4000)
    begin
      num_errors++;
      results();
    end
  initial
  begin
    i = $urandom(49);
    repeat (5) @(posedge clk_i);
    reset_n_i <= 1'b1;
    @(posedge clk_i);
    // loops: both widths, end displacements, reaching zero and wrapping
    for (i = 0; i < 6; i++)
    begin
      d = {$urandom, $urandom};
      if (i < 3) d[15:0] = (i == 0) ? 16'h0101 : (i == 1) ? 16'h0100 : 16'h0000;
      dp = (i == 0) ? 7'h00 : (i == 1) ? 7'h7F : 7'($urandom);
      a = 16'($urandom);
      c = i[0] ? d[15:0] - 16'h0001 : {8'h00, d[7:0] - 8'h01};
      n = '{rdw: 1'b1, sz: {2'b00, i[0]}, msk: i[0] ? 64'hFFFF : 64'hFF, wd: 64'(c),
        pcl: c != 16'h0000, pco: a - {dp, 1'b0}, cyc: 11, default: 0};
      rd_data_i <= d;
      next_pc_i <= a;
      pc_seg_i <= 8'($urandom);
      op({`LISHX_LOOP_TOP, 4'($urandom), i[0], dp}, n, -1);
    end
    // interrupt enable: every select pair over random current enables
    for (i = 0; i < 4; i++)
    begin
      f = 2'($urandom);
      {vi_en_i, nvi_en_i} <= f;
      n = '{flag_control_word: 1'b1, vi: f[1] | ~i[1], nonvectored_irq_enable: f[0] | ~i[0], cyc: 7, default: 0};
      op({`LISHX_EI_HI, `LISHX_EI_LO6, i[1:0]}, n, -1);
    end
    // sign extension: each size with each sign
    for (i = 0; i < 6; i++)
    begin
      d = {$urandom, $urandom};
      {d[31], d[15], d[7]} = {i[0], ~i[0], i[0]};
      n = '{rdw: 1'b1, sz: 3'(i % 3 + 1), msk: '1, sel: 4'h2, cyc: 11, default: 0};
      n.wd = (i % 3 == 0) ? {48'h0, {8{d[7]}}, d[7:0]} : (i % 3 == 1) ?
        {32'h0, {16{d[15]}}, d[15:0]} : {{32{d[31]}}, d[31:0]};
      rd_data_i <= d;
      op({`LISHX_EXT_TOP, 4'h2, (i % 3 == 0) ? `LISHX_EXT_B : (i % 3 == 1) ?
        `LISHX_EXT_W : `LISHX_EXT_L}, n, -1);
    end
    // port input: indirect and direct, both widths and cycle kinds, one slow port
    for (i = 0; i < 6; i++)
    begin
      a = 16'($urandom);
      lat <= (i == 4) ? 8'h0E : 8'h00;
      rs_data_i <= a;
      ext_word_i <= a;
      n = '{rdw: 1'b1, sz: {2'b00, i[0]}, msk: i[0] ? 64'hFFFF : 64'hFF, default: 0};
      n.wd = 64'((a ^ 16'h5A3C) & (i[0] ? 16'hFFFF : 16'h00FF));
      n.cyc = (i == 4) ? 0 : (i < 2) ? 10 : 12;
      n.sel = (i < 2) ? 4'h2 : 4'h3;
      op((i < 2) ? {`LISHX_IN_IR_TOP, i[0], 4'h6, 4'h2} : {`LISHX_IN_DA_TOP, i[0], 4'h3,
        `LISHX_IN_DA_SUB, i[0] ^ i[1]}, n, -1);
    end
    // halt: interrupt seen from cycle 21, taken at the period end on cycle 23
    n = '{cyc: 23, default: 0};
    op({`LISHX_HALT_HI, `LISHX_HALT_LO}, n, 20);
    // privileged forms in normal mode trap after one cycle
    system_mode_i <= 1'b0;
    n = '{trp: 1'b1, cyc: 1, default: 0};
    op({`LISHX_EI_HI, `LISHX_EI_LO6, 2'b00}, n, -1);
    op({`LISHX_HALT_HI, `LISHX_HALT_LO}, n, -1);
    op({`LISHX_IN_DA_TOP, 1'b1, 4'h1, `LISHX_IN_DA_SUB, 1'b1}, n, -1);
    repeat (2) @(posedge clk_i);
    results();
  end
endmodule
